// File: rtl/seq_map.vh
/*
 * constants of the instruction sequencer: widths, phases, reset values,
 * instruction field positions, opcodes and alu operation codes.
 * assumes it is included by bare name in every design file that needs it.
 */
`ifndef SEQ_MAP_VH
`define SEQ_MAP_VH

`define PC_W         10
`define IR_W         14
`define DA_W         7
`define DW           8

`define PC_RESET     10'h000
`define PC_ONE       10'h001
`define IR_RESET     14'h0000
`define BYTE_ZERO    8'h00
`define BYTE_ONE     8'h01
`define DA_RESET     7'h00

// four system clocks per instruction cycle
`define PHASE_W      2
`define PHASE_FIRST  2'h0
`define PHASE_CAPT   2'h1
`define PHASE_WSET   2'h2
`define PHASE_LAST   2'h3
`define PHASE_STEP   2'h1

// address of the program counter low byte in data space
`define PCL_ADDR     7'h06

// instruction fields
`define F_CLASS      13:12
`define F_MOP        11:7
`define F_IOP        11:8
`define F_BOP        11:10
`define F_BIT        9:7
`define F_MADDR      6:0
`define F_IMM        7:0
`define F_JADDR      9:0
`define F_CALL       11
`define F_MISC       1:0
`define F_PAGE       9:8

// instruction classes
`define CLS_MEM      2'h0
`define CLS_BIT      2'h1
`define CLS_JMP      2'h2
`define CLS_IMM      2'h3

// memory class opcodes
`define OP_MISC      5'h00
`define OP_MOV_A_M   5'h01
`define OP_MOV_M_A   5'h02
`define OP_ADD       5'h03
`define OP_ADDM      5'h04
`define OP_ADC       5'h05
`define OP_ADCM      5'h06
`define OP_SUB       5'h07
`define OP_SUBM      5'h08
`define OP_SBC       5'h09
`define OP_SBCM      5'h0a
`define OP_AND       5'h0b
`define OP_OR        5'h0c
`define OP_XOR       5'h0d
`define OP_ANDM      5'h0e
`define OP_ORM       5'h0f
`define OP_XORM      5'h10
`define OP_CPL       5'h11
`define OP_CPLA      5'h12
`define OP_INC       5'h13
`define OP_ADD_ONE_INTO_WORKING_REG      5'h14
`define OP_DEC       5'h15
`define OP_SUBTRACT_ONE_INTO_WORKING_REG      5'h16
`define OP_RR        5'h17
`define OP_RL        5'h18
`define OP_RRC       5'h19
`define OP_RLC       5'h1a
`define OP_SZ        5'h1b
`define OP_SIZ       5'h1c
`define OP_SDZ       5'h1d
`define OP_CLR       5'h1e
`define OP_TAB       5'h1f

// misc subcodes in the address field
`define MISC_RET     2'h1
`define MISC_BACK_FROM_INTERRUPT    2'h2

// bit class subcodes
`define BOP_SET      2'h0
`define BOP_CLR      2'h1
`define BOP_SKIP_SET 2'h2
`define BOP_SKIP_CLR 2'h3

// immediate class subcodes
`define IOP_MOV      4'h0
`define IOP_ADD      4'h1
`define IOP_SUB      4'h2
`define IOP_AND      4'h3
`define IOP_OR       4'h4
`define IOP_XOR      4'h5

// alu operations
`define ALU_W        4
`define ALU_PASS     4'h0
`define ALU_ADD      4'h1
`define ALU_ADC      4'h2
`define ALU_SUB      4'h3
`define ALU_SBC      4'h4
`define ALU_AND      4'h5
`define ALU_OR       4'h6
`define ALU_XOR      4'h7
`define ALU_CPL      4'h8
`define ALU_INC      4'h9
`define ALU_DEC      4'ha
`define ALU_RR       4'hb
`define ALU_RL       4'hc
`define ALU_RRC      4'hd
`define ALU_RLC      4'he
`define ALU_ZERO     4'hf

`endif

// File: rtl/phase_gen.v
/*
 * instruction cycle phase counter: four system clocks per instruction cycle.
 * assumes one clock mclk and an asynchronous active-low reset.
 */
`timescale 1ns/1ns
`include "seq_map.vh"
module phase_gen (
	input  wire                 mclk,
	input  wire                 rst_n,
	output reg  [`PHASE_W-1:0] phase,
	output wire                 last
);

assign last = (phase == `PHASE_LAST);

always @(posedge mclk or negedge rst_n)
begin
	if (!rst_n)
		phase <= `PHASE_FIRST;
	else
		phase <= phase + `PHASE_STEP;
end

endmodule

// File: rtl/alu_unit.v
/*
 * combinational 8-bit alu of the core: add/sub with carry, logic,
 * increment/decrement, rotates.
 * assumes operands and carry-in are stable for the phases that use them.
 */
`timescale 1ns/1ns
`include "seq_map.vh"
module alu_unit (
	input  wire [`ALU_W-1:0] op,
	input  wire [`DW-1:0]    a,
	input  wire [`DW-1:0]    b,
	input  wire              cin,
	output reg  [`DW-1:0]    res,
	output reg               cout,
	output reg               acout,
	output reg               ovout
);

reg [`DW-1:0] bx;
reg           ci;
reg [`DW:0]   sum;
reg [4:0]     nib;

always @*
begin
	bx = b;
	ci = 1'b0;
	if (op == `ALU_SUB || op == `ALU_SBC)
		bx = ~b;
	if (op == `ALU_SUB)
		ci = 1'b1;
	else if (op == `ALU_ADC || op == `ALU_SBC)
		ci = cin;
	sum = {1'b0, a} + {1'b0, bx} + {{`DW{1'b0}}, ci};
	nib = {1'b0, a[3:0]} + {1'b0, bx[3:0]} + {4'h0, ci};
	// sub: carry set means no borrow
	cout = sum[`DW];
	acout = nib[4];
	ovout = (a[`DW-1] == bx[`DW-1]) && (sum[`DW-1] != a[`DW-1]);
	case (op)
		`ALU_PASS: res = b;
		`ALU_ADD,
		`ALU_ADC,
		`ALU_SUB,
		`ALU_SBC:  res = sum[`DW-1:0];
		`ALU_AND:  res = a & b;
		`ALU_OR:   res = a | b;
		`ALU_XOR:  res = a ^ b;
		`ALU_CPL:  res = ~b;
		`ALU_INC:  res = b + `BYTE_ONE;
		`ALU_DEC:  res = b - `BYTE_ONE;
		`ALU_RR:   res = {b[0], b[`DW-1:1]};
		`ALU_RL:   res = {b[`DW-2:0], b[`DW-1]};
		`ALU_RRC:
		begin
			res = {cin, b[`DW-1:1]};
			cout = b[0];
		end
		`ALU_RLC:
		begin
			res = {b[`DW-2:0], cin};
			cout = b[`DW-1];
		end
		default:   res = `BYTE_ZERO;
	endcase
end

endmodule

// File: rtl/mcu_instruction_sequencer.v
/*
 * instruction sequencer of a small 8-bit core: fetch, decode, execute,
 * skips, jumps, one-level call/return, table read, flags.
 * assumes program memory and data memory are synchronous on mclk with one
 * clock read latency, and data memory writes on an mclk edge with data_we high.
 */
// Contract
// [RULE1] one instruction cycle is four system clocks and all timing counts in instruction cycles.
// [RULE2] ordinary instructions take one cycle; jump, call, return, interrupt return and table read take two.
// [RULE3] an instruction writing the program counter low byte acts as a jump and takes one extra cycle; a table read into that byte does not jump.
// [RULE4] a conditional skip takes two cycles when it skips and one when it does not.
// [RULE5] a call saves the following address and the matching return resumes exactly there.
// [RULE6] an unconditional jump loads the target and saves no return address.
// [RULE7] conditional branches test a data byte or a single bit and then execute or skip the next instruction.
// [RULE8] moves go register to working register, working register to register, and immediate to working register.
// [RULE9] add sets carry above 255 and subtract shows a borrow below zero through the carry flag.
// [RULE10] increment and decrement change the operand by one into memory or the working register.
// [RULE11] logical operations go through the working register and set the zero flag on a zero result.
// [RULE12] rotates shift one bit left or right and the through-carry forms move the leaving bit into carry.
// [RULE13] bit set and clear change only the selected bit through an internal read-modify-write.
// [RULE14] add and subtract update zero, carry, auxiliary carry and overflow, in one cycle.
// [RULE15] a flow change drops the already fetched instruction and fetches the new address in the second cycle.
`timescale 1ns/1ns
`include "seq_map.vh"
module mcu_instruction_sequencer (
	input  wire                 mclk,
	input  wire                 rst_n,
	output reg  [`PC_W-1:0]     prog_addr,
	input  wire [`IR_W-1:0]     prog_data,
	output wire [`DA_W-1:0]     data_addr,
	input  wire [`DW-1:0]       data_rdata,
	output reg  [`DW-1:0]       data_wdata,
	output reg                  data_we,
	output wire [`PHASE_W-1:0]  cycle_phase,
	output reg  [`DW-1:0]       working_register,
	output reg                  flag_z,
	output reg                  flag_c,
	output reg                  flag_ac,
	output reg                  flag_ov
);

wire                 phase_last;
reg  [`PC_W-1:0]     pc;
reg  [`IR_W-1:0]     ir;
reg                  ir_valid;
reg                  stall_tab;
reg  [`DA_W-1:0]     tab_dest;
reg  [`PC_W-1:0]     ret_addr;
reg  [`DW-1:0]       mem_q;

reg  [`ALU_W-1:0]    alu_op;
reg  [`DW-1:0]       opnd_b;
wire [`DW-1:0]       alu_res;
wire                 alu_c;
wire                 alu_ac;
wire                 alu_ov;
reg                  sel_bit;
reg  [`DW-1:0]       bit_res;
reg                  wr_acc;
reg                  wr_mem;
reg                  upd_z;
reg                  upd_c;
reg                  upd_arith;
reg                  skip;
reg                  jump;
reg                  call;
reg                  tab;
reg  [`PC_W-1:0]     target;
wire [`DW-1:0]       res;
wire                 pcl_hit;
wire                 redirect;
wire                 exec;
wire [`DW-1:0]       bit_mask;

wire [1:0]           cls   = ir[`F_CLASS];
wire [4:0]           mop   = ir[`F_MOP];
wire [3:0]           iop   = ir[`F_IOP];
wire [1:0]           bop   = ir[`F_BOP];
wire [2:0]           bsel  = ir[`F_BIT];
wire [`DA_W-1:0]     maddr = ir[`F_MADDR];
wire [`DW-1:0]       imm   = ir[`F_IMM];

function [`ALU_W-1:0] mem_alu;
	input [4:0] op;
	begin
		case (op)
			`OP_ADD,  `OP_ADDM: mem_alu = `ALU_ADD;
			`OP_ADC,  `OP_ADCM: mem_alu = `ALU_ADC;
			`OP_SUB,  `OP_SUBM: mem_alu = `ALU_SUB;
			`OP_SBC,  `OP_SBCM: mem_alu = `ALU_SBC;
			`OP_AND,  `OP_ANDM: mem_alu = `ALU_AND;
			`OP_OR,   `OP_ORM:  mem_alu = `ALU_OR;
			`OP_XOR,  `OP_XORM: mem_alu = `ALU_XOR;
			`OP_CPL,  `OP_CPLA: mem_alu = `ALU_CPL;
			`OP_INC,  `OP_ADD_ONE_INTO_WORKING_REG,
			`OP_SIZ:            mem_alu = `ALU_INC;
			`OP_DEC,  `OP_SUBTRACT_ONE_INTO_WORKING_REG,
			`OP_SDZ:            mem_alu = `ALU_DEC;
			`OP_RR:             mem_alu = `ALU_RR;
			`OP_RL:             mem_alu = `ALU_RL;
			`OP_RRC:            mem_alu = `ALU_RRC;
			`OP_RLC:            mem_alu = `ALU_RLC;
			`OP_CLR:            mem_alu = `ALU_ZERO;
			default:            mem_alu = `ALU_PASS;
		endcase
	end
endfunction

function [`ALU_W-1:0] imm_alu;
	input [3:0] op;
	begin
		case (op)
			`IOP_ADD: imm_alu = `ALU_ADD;
			`IOP_SUB: imm_alu = `ALU_SUB;
			`IOP_AND: imm_alu = `ALU_AND;
			`IOP_OR:  imm_alu = `ALU_OR;
			`IOP_XOR: imm_alu = `ALU_XOR;
			default:  imm_alu = `ALU_PASS;
		endcase
	end
endfunction

phase_gen u_phase (
	.mclk  (mclk),
	.rst_n (rst_n),
	.phase (cycle_phase),
	.last  (phase_last)
);

alu_unit u_alu (
	.op    (alu_op),
	.a     (working_register),
	.b     (opnd_b),
	.cin   (flag_c),
	.res   (alu_res),
	.cout  (alu_c),
	.acout (alu_ac),
	.ovout (alu_ov)
);

// no instruction executes in the table fetch cycle or after a flush
assign exec      = ir_valid && !stall_tab;
assign bit_mask  = `BYTE_ONE << bsel;
assign res       = sel_bit ? bit_res : alu_res;
assign pcl_hit   = wr_mem && (maddr == `PCL_ADDR);
assign redirect  = jump || pcl_hit;
assign data_addr = stall_tab ? tab_dest : maddr;

always @*
begin
	alu_op    = `ALU_PASS;
	opnd_b    = mem_q;
	sel_bit   = 1'b0;
	bit_res   = mem_q;
	wr_acc    = 1'b0;
	wr_mem    = 1'b0;
	upd_z     = 1'b0;
	upd_c     = 1'b0;
	upd_arith = 1'b0;
	skip      = 1'b0;
	jump      = 1'b0;
	call      = 1'b0;
	tab       = 1'b0;
	target    = ir[`F_JADDR];
	if (exec)
	begin
		case (cls)
			`CLS_MEM:
			begin
				alu_op = mem_alu(mop);
				case (mop)
					`OP_MISC:
					begin
						if (ir[`F_MISC] == `MISC_RET || ir[`F_MISC] == `MISC_BACK_FROM_INTERRUPT)
						begin
							jump   = 1'b1;              // see [RULE5]
							target = ret_addr;
						end
					end
					`OP_MOV_A_M: wr_acc = 1'b1;         // see [RULE8]
					`OP_MOV_M_A:
					begin
						opnd_b = working_register;      // see [RULE8]
						wr_mem = 1'b1;
					end
					`OP_ADD, `OP_ADC, `OP_SUB, `OP_SBC:
					begin
						wr_acc    = 1'b1;               // see [RULE9]
						upd_arith = 1'b1;               // see [RULE14]
					end
					`OP_ADDM, `OP_ADCM, `OP_SUBM, `OP_SBCM:
					begin
						wr_mem    = 1'b1;               // see [RULE9]
						upd_arith = 1'b1;               // see [RULE14]
					end
					`OP_AND, `OP_OR, `OP_XOR, `OP_CPLA, `OP_ADD_ONE_INTO_WORKING_REG, `OP_SUBTRACT_ONE_INTO_WORKING_REG:
					begin
						wr_acc = 1'b1;                  // see [RULE11] see [RULE10]
						upd_z  = 1'b1;
					end
					`OP_ANDM, `OP_ORM, `OP_XORM, `OP_CPL, `OP_INC, `OP_DEC:
					begin
						wr_mem = 1'b1;                  // see [RULE11] see [RULE10]
						upd_z  = 1'b1;
					end
					`OP_RR, `OP_RL: wr_mem = 1'b1;      // see [RULE12]
					`OP_RRC, `OP_RLC:
					begin
						wr_mem = 1'b1;                  // see [RULE12]
						upd_c  = 1'b1;
					end
					`OP_SZ: skip = (mem_q == `BYTE_ZERO); // see [RULE7]
					`OP_SIZ, `OP_SDZ:
					begin
						wr_mem = 1'b1;
						skip   = (alu_res == `BYTE_ZERO); // see [RULE7]
					end
					`OP_CLR: wr_mem = 1'b1;
					`OP_TAB: tab = 1'b1;                // see [RULE2]
					default: wr_mem = 1'b0;
				endcase
			end
			`CLS_BIT:
			begin
				sel_bit = 1'b1;
				case (bop)
					`BOP_SET:
					begin
						bit_res = mem_q | bit_mask;     // see [RULE13]
						wr_mem  = 1'b1;
					end
					`BOP_CLR:
					begin
						bit_res = mem_q & ~bit_mask;    // see [RULE13]
						wr_mem  = 1'b1;
					end
					`BOP_SKIP_SET: skip = mem_q[bsel];  // see [RULE7]
					default:       skip = !mem_q[bsel];
				endcase
			end
			`CLS_JMP:
			begin
				jump = 1'b1;                            // see [RULE6]
				call = ir[`F_CALL];                     // see [RULE5]
			end
			default:
			begin
				opnd_b = imm;
				alu_op = imm_alu(iop);
				if (iop <= `IOP_XOR)
				begin
					wr_acc    = 1'b1;                   // see [RULE8]
					upd_z     = (iop >= `IOP_AND);      // see [RULE11]
					upd_arith = (iop == `IOP_ADD) || (iop == `IOP_SUB); // see [RULE14]
				end
			end
		endcase
		if (pcl_hit)
			target = {pc[`F_PAGE], res};                // see [RULE3]
	end
end

// operand capture and write strobe inside the instruction cycle
always @(posedge mclk or negedge rst_n)
begin
	if (!rst_n)
	begin
		mem_q      <= `BYTE_ZERO;
		data_wdata <= `BYTE_ZERO;
		data_we    <= 1'b0;
	end
	else
	begin
		if (cycle_phase == `PHASE_CAPT)
			mem_q <= data_rdata;
		if (cycle_phase == `PHASE_WSET)
		begin
			// internal read-modify-write; writes to the low pc byte go to the pc, except a table read's, which goes to data memory
			data_we    <= stall_tab || (wr_mem && !pcl_hit); // see [RULE13] see [RULE3]
			data_wdata <= stall_tab ? prog_data[`DW-1:0] : res;
		end
		else
			data_we <= 1'b0;
	end
end

// fetch, flow change and architectural state, once per instruction cycle
always @(posedge mclk or negedge rst_n)
begin
	if (!rst_n)
	begin
		pc               <= `PC_RESET;
		prog_addr        <= `PC_RESET;
		ir               <= `IR_RESET;
		ir_valid         <= 1'b0;
		stall_tab        <= 1'b0;
		tab_dest         <= `DA_RESET;
		ret_addr         <= `PC_RESET;
		working_register <= `BYTE_ZERO;
		flag_z           <= 1'b0;
		flag_c           <= 1'b0;
		flag_ac          <= 1'b0;
		flag_ov          <= 1'b0;
	end
	else if (phase_last)                                // see [RULE1]
	begin
		if (stall_tab)
		begin
			stall_tab <= 1'b0;                          // see [RULE2]
			prog_addr <= pc;
		end
		else if (redirect)
		begin
			pc        <= target;                        // see [RULE15]
			prog_addr <= target;
			ir_valid  <= 1'b0;                          // see [RULE2] see [RULE3]
			if (call)
				ret_addr <= pc;                         // see [RULE5]
		end
		else if (tab)
		begin
			ir        <= prog_data;
			ir_valid  <= 1'b1;
			pc        <= pc + `PC_ONE;
			prog_addr <= {pc[`F_PAGE], working_register};
			stall_tab <= 1'b1;
			tab_dest  <= maddr;
		end
		else
		begin
			ir        <= prog_data;
			ir_valid  <= !skip;                         // see [RULE4]
			pc        <= pc + `PC_ONE;
			prog_addr <= pc + `PC_ONE;
		end
		if (wr_acc)
			working_register <= res;
		if (upd_z || upd_arith)
			flag_z <= (res == `BYTE_ZERO);              // see [RULE11]
		if (upd_c || upd_arith)
			flag_c <= alu_c;                            // see [RULE9] see [RULE12]
		if (upd_arith)
		begin
			flag_ac <= alu_ac;                          // see [RULE14]
			flag_ov <= alu_ov;
		end
	end
end

endmodule

// File: dv/mcu_instruction_sequencer_sva.sv
/*
 * port checker of the instruction sequencer: phase order, commit points, write strobe.
 * assumes one clock mclk and active-low rst_n; bound from the bench top.
 */
`timescale 1ns/1ns
`include "seq_map.vh"
module mcu_instruction_sequencer_sva (
	input wire logic                 mclk,
	input wire logic                 rst_n,
	input wire logic [`PC_W-1:0]     prog_addr,
	input wire logic [`IR_W-1:0]     prog_data,
	input wire logic [`DA_W-1:0]     data_addr,
	input wire logic [`DW-1:0]       data_rdata,
	input wire logic [`DW-1:0]       data_wdata,
	input wire logic                 data_we,
	input wire logic [`PHASE_W-1:0]  cycle_phase,
	input wire logic [`DW-1:0]       working_register,
	input wire logic                 flag_z,
	input wire logic                 flag_c,
	input wire logic                 flag_ac,
	input wire logic                 flag_ov
);
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!rst_n);

	chk_phase_order: assert property (
		cycle_phase == `PHASE_FIRST |=> cycle_phase == `PHASE_CAPT ##1 cycle_phase == `PHASE_WSET
		##1 cycle_phase == `PHASE_LAST ##1 cycle_phase == `PHASE_FIRST)
		else $error("phase order broken");
	chk_reset_vals: assert property (
		$rose(rst_n) |-> prog_addr == `PC_RESET && cycle_phase == `PHASE_FIRST && working_register == `BYTE_ZERO)
		else $error("state after reset wrong");
	chk_first_idle: assert property ($rose(rst_n) |-> (!data_we)[*7])
		else $error("write in first cycle after reset");
	chk_we_phase: assert property (data_we |-> cycle_phase == `PHASE_LAST)
		else $error("write strobe outside last phase");
	chk_we_pulse: assert property (data_we |=> (!data_we)[*3])
		else $error("write strobe too long");
	chk_pc_hold: assert property ($changed(prog_addr) |-> $past(cycle_phase) == `PHASE_LAST)
		else $error("fetch address moved mid cycle");
	chk_acc_commit: assert property ($changed(working_register) |-> $past(cycle_phase) == `PHASE_LAST)
		else $error("working register moved mid cycle");
	chk_flag_commit: assert property (
		$changed({flag_z, flag_c, flag_ac, flag_ov}) |-> $past(cycle_phase) == `PHASE_LAST)
		else $error("flags moved mid cycle");
	chk_wdata_setup: assert property ($changed(data_wdata) |-> $past(cycle_phase) == `PHASE_WSET)
		else $error("write data moved outside phase 2");
	chk_pcl_guard: assert property (data_we |-> data_addr != `PCL_ADDR)
		else $error("memory write to program counter low byte");

	cover property (data_we);
	cover property ($changed(prog_addr) && prog_addr != $past(prog_addr) + `PC_ONE);
	cover property ($rose(flag_c));
	cover property ($changed(prog_addr) && prog_addr == 10'h030);
endmodule

// File: dv/seq_mem_model.sv
/*
 * program and data memory beside the sequencer, one clock read latency.
 * assumes the bench loads both arrays during reset and reads the write log.
 */
`timescale 1ns/1ns
`include "seq_map.vh"
module seq_mem_model (
	input  wire logic                mclk,
	input  wire logic                rst_n,
	input  wire logic [`PC_W-1:0]    prog_addr,
	output logic      [`IR_W-1:0]    prog_data,
	input  wire logic [`DA_W-1:0]    data_addr,
	output logic      [`DW-1:0]      data_rdata,
	input  wire logic [`DW-1:0]      data_wdata,
	input  wire logic                data_we,
	input  wire logic [`PHASE_W-1:0] cycle_phase
);
	logic [`IR_W-1:0] prog [0:1023];
	logic [`DW-1:0]   data [0:127];
	int               cyc;
	logic [31:0]      wlog [$];
	// instruction cycle index since reset
	always @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
			cyc <= 0;
		else if (cycle_phase == `PHASE_LAST)
			cyc <= cyc + 1;
	end
	always @(posedge mclk)
	begin
		prog_data <= prog[prog_addr];
		data_rdata <= data[data_addr];
		if (rst_n && data_we)
		begin
			data[data_addr] <= data_wdata;
			wlog.push_back({cyc[15:0], 1'b0, data_addr, data_wdata});
		end
	end
endmodule

// File: dv/test_mcu_instruction_sequencer.sv
/*
 * self-checking bench of the sequencer: random operands through a fixed program.
 * assumes the memory model logs writes with their instruction cycle index.
 */
`timescale 1ns/1ns
`include "seq_map.vh"
module test_mcu_instruction_sequencer;
	logic                 mclk = 1'b0;
	logic                 rst_n = 1'b0;
	wire [`PC_W-1:0]      prog_addr;
	wire [`IR_W-1:0]      prog_data;
	wire [`DA_W-1:0]      data_addr;
	wire [`DW-1:0]        data_rdata;
	wire [`DW-1:0]        data_wdata;
	wire                  data_we;
	wire [`PHASE_W-1:0]   cycle_phase;
	wire [`DW-1:0]        working_register;
	wire                  flag_z, flag_c, flag_ac, flag_ov;
	int                   err_count = 0;
	int                   samples_checked = 0;
	logic [31:0]          seed = 32'h8749;

	always #20 mclk = ~mclk;

	mcu_instruction_sequencer u_dut (.mclk(mclk), .rst_n(rst_n), .prog_addr(prog_addr), .prog_data(prog_data),
		.data_addr(data_addr), .data_rdata(data_rdata), .data_wdata(data_wdata), .data_we(data_we),
		.cycle_phase(cycle_phase), .working_register(working_register), .flag_z(flag_z), .flag_c(flag_c),
		.flag_ac(flag_ac), .flag_ov(flag_ov));
	seq_mem_model u_mem (.mclk(mclk), .rst_n(rst_n), .prog_addr(prog_addr), .prog_data(prog_data),
		.data_addr(data_addr), .data_rdata(data_rdata), .data_wdata(data_wdata), .data_we(data_we),
		.cycle_phase(cycle_phase));

	function automatic logic [31:0] lfsr_next(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	function automatic logic [8:0] add9(input logic [7:0] a, input logic [7:0] b);
		return {1'b0, a} + {1'b0, b};
	endfunction
	function automatic logic [31:0] log_word(input int c, input logic [6:0] a, input logic [7:0] d);
		return {c[15:0], 1'b0, a, d};
	endfunction

	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		samples_checked++;
		if (got !== exp)
		begin
			err_count++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic wait_cyc(input int n);
		for (int k = 0; k < 400 && u_mem.cyc < n; k++)
			@(posedge mclk);
		@(negedge mclk);
	endtask
	task automatic tally_and_finish;
		$display("checks %0d errors %0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	initial
	begin
		#200000;
		err_count++;
		$display("Error watchdog expected done seen hang");
		tally_and_finish;
	end

	initial
	begin
		logic [7:0]  r1, m, r2, v, b0, dif, vi;
		logic [8:0]  sum;
		logic [31:0] exp_log [8];
		for (int it = 0; it < 4; it++)
		begin
			seed = lfsr_next(seed);
			{r1, m, r2, v} = seed;
			b0 = seed[7:0] ^ seed[31:24];
			if (it == 0)
			begin
				// carry out, zero sum, borrow, increment wrap
				{r1, m, r2, v, b0} = {8'hff, 8'h01, 8'h01, 8'hff, 8'hf7};
			end
			if (it != 0) @(posedge mclk);
			rst_n <= 1'b0;
			for (int a = 0; a < 1024; a++)
				u_mem.prog[a] = `IR_RESET;
			for (int a = 0; a < 128; a++)
				u_mem.data[a] = `BYTE_ZERO;
			u_mem.wlog.delete();
			u_mem.data[7'h10] = m;
			u_mem.data[7'h14] = b0;
			u_mem.data[7'h18] = v;
			u_mem.prog[0] = {`CLS_IMM, `IOP_MOV, r1};
			u_mem.prog[1] = {`CLS_MEM, `OP_ADD, 7'h10};
			u_mem.prog[2] = {`CLS_MEM, `OP_MOV_M_A, 7'h11};
			u_mem.prog[3] = {`CLS_IMM, `IOP_SUB, r2};
			u_mem.prog[4] = {`CLS_MEM, `OP_MOV_M_A, 7'h12};
			u_mem.prog[5] = {`CLS_JMP, 2'b10, 10'h020};
			u_mem.prog[6] = {`CLS_MEM, `OP_MOV_M_A, 7'h13};
			u_mem.prog[7] = {`CLS_JMP, 2'b00, 10'h009};
			u_mem.prog[8] = {`CLS_MEM, `OP_MOV_M_A, 7'h19};
			u_mem.prog[9] = {`CLS_MEM, `OP_RLC, 7'h18};
			u_mem.prog[10] = {`CLS_IMM, `IOP_MOV, 8'h30};
			// write to the low pc byte jumps to 0x30; prog[12] must never run
			u_mem.prog[11] = {`CLS_MEM, `OP_MOV_M_A, `PCL_ADDR};
			u_mem.prog[12] = {`CLS_MEM, `OP_MOV_M_A, 7'h19};
			u_mem.prog[32] = {`CLS_BIT, `BOP_SET, 3'h3, 7'h14};
			u_mem.prog[33] = {`CLS_MEM, `OP_SZ, 7'h15};
			u_mem.prog[34] = {`CLS_IMM, `IOP_MOV, 8'hee};
			u_mem.prog[35] = {`CLS_IMM, `IOP_OR, `BYTE_ZERO};
			u_mem.prog[36] = {`CLS_MEM, `OP_INC, 7'h18};
			u_mem.prog[37] = {`CLS_MEM, `OP_MISC, 5'h00, `MISC_RET};
			u_mem.prog[48] = {`CLS_IMM, `IOP_MOV, 8'h3f};
			u_mem.prog[49] = {`CLS_MEM, `OP_TAB, 7'h1a};
			// nonzero byte: no skip, one cycle
			u_mem.prog[50] = {`CLS_MEM, `OP_SZ, 7'h14};
			u_mem.prog[51] = {`CLS_MEM, `OP_MOV_M_A, 7'h1b};
			u_mem.prog[52] = {`CLS_JMP, 2'b00, 10'h034};
			u_mem.prog[63] = {6'h00, r2};
			repeat (6) @(posedge mclk);
			rst_n <= 1'b1;
			sum = add9(r1, m);
			dif = sum[7:0] - r2;
			vi = v + `BYTE_ONE;
			exp_log[0] = log_word(3, 7'h11, sum[7:0]);
			exp_log[1] = log_word(5, 7'h12, dif);
			exp_log[2] = log_word(8, 7'h14, b0 | 8'h08);
			exp_log[3] = log_word(12, 7'h18, vi);
			exp_log[4] = log_word(15, 7'h13, dif);
			exp_log[5] = log_word(18, 7'h18, {vi[6:0], sum[7:0] >= r2});
			exp_log[6] = log_word(24, 7'h1a, r2);
			exp_log[7] = log_word(26, 7'h1b, 8'h3f);
			// add commits at the end of cycle 2
			wait_cyc(3);
			check("add carry", {31'h0, sum[8]}, {31'h0, flag_c});
			check("add zero", {31'h0, sum[7:0] == `BYTE_ZERO}, {31'h0, flag_z});
			check("add aux carry", {31'h0, ({1'b0, r1[3:0]} + {1'b0, m[3:0]}) > 5'h0f}, {31'h0, flag_ac});
			check("add overflow", {31'h0, (r1[7] == m[7]) && (sum[7] != r1[7])}, {31'h0, flag_ov});
			wait_cyc(5);
			check("sub carry", {31'h0, sum[7:0] >= r2}, {31'h0, flag_c});
			check("sub zero", {31'h0, dif == `BYTE_ZERO}, {31'h0, flag_z});
			check("sub aux carry", {31'h0, sum[3:0] >= r2[3:0]}, {31'h0, flag_ac});
			check("sub overflow", {31'h0, (sum[7] != r2[7]) && (dif[7] != sum[7])}, {31'h0, flag_ov});
			wait_cyc(16);
			check("working register", {24'h0, dif}, {24'h0, working_register});
			check("inc zero", {31'h0, v == 8'hff}, {31'h0, flag_z});
			wait_cyc(30);
			check("write count", 32'd8, u_mem.wlog.size());
			for (int i = 0; i < 8 && i < u_mem.wlog.size(); i++)
				check("write log", exp_log[i], u_mem.wlog[i]);
			check("rotate carry", {31'h0, vi[7]}, {31'h0, flag_c});
			check("working register", {24'h0, 8'h3f}, {24'h0, working_register});
		end
		tally_and_finish;
	end
endmodule

bind mcu_instruction_sequencer mcu_instruction_sequencer_sva u_sva (.mclk(mclk), .rst_n(rst_n),
	.prog_addr(prog_addr), .prog_data(prog_data), .data_addr(data_addr), .data_rdata(data_rdata),
	.data_wdata(data_wdata), .data_we(data_we), .cycle_phase(cycle_phase), .working_register(working_register),
	.flag_z(flag_z), .flag_c(flag_c), .flag_ac(flag_ac), .flag_ov(flag_ov));
